/* iscu_pkg.sv */
package iscu_pkg;
  // ***********************
  // command codes
  // ***********************
  localparam logic [7:0] CMD_IDLE = 8'he3;
  localparam logic [7:0] CMD_IDLE_IMM = 8'he1;
  localparam logic [7:0] CMD_INIT_GEOM = 8'h91;

  // ***********************
  // timer decode
  // ***********************
  localparam logic [7:0] CNT_SEC_MAX = 8'hf0;
  localparam logic [7:0] CNT_HALFHR_MAX = 8'hfb;
  localparam logic [7:0] CNT_21MIN = 8'hfc;
  localparam logic [7:0] CNT_8HR = 8'hfd;
  localparam logic [7:0] CNT_RSVD = 8'hfe;
  localparam logic [7:0] CNT_21M15S = 8'hff;
  localparam logic [7:0] CNT_HALFHR_BASE = 8'hf0;
  localparam int SEC_PER_UNIT = 5;
  localparam int SEC_PER_HALFHR = 1800;
  localparam int SEC_21MIN = 1260;
  localparam int SEC_8HR = 28800;
  localparam int SEC_21M15S = 1275;
  localparam int SPINDOWN_SEC = 60;

  // ***********************
  // timing
  // ***********************
  localparam int CLK_HZ = 10000000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam logic [1:0] RESET_MODE = 2'h0;
endpackage : iscu_pkg

/* iscu_unit.sv */
module iscu_unit #(
  parameter int TICK_CYCLES = iscu_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // task file command (same clock domain)
  input wire logic cmd_wr_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [7:0] sector_count_in,
  input wire logic [3:0] drive_head_in,
  // spindle
  input wire logic spindle_turning_in,
  // status
  output logic busy_out,
  output logic irq_out,
  output logic spinup_req_out,
  output logic [1:0] power_mode_out,
  output logic standby_enabled_out,
  output logic [7:0] geom_sectors_out,
  output logic [3:0] geom_heads_m1_out
);
  // ***********************
  // types and functions
  // ***********************
  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_IDLE = 2'b01,
    PM_STANDBY = 2'b10
  } iscu_mode_type;

  function automatic logic [15:0] timeout_sec(input logic [7:0] cnt);
    logic [15:0] r;
    r = 16'h0000;
    if (cnt <= iscu_pkg::CNT_SEC_MAX) begin
      r = 16'(cnt) * 16'(iscu_pkg::SEC_PER_UNIT);
    end else if (cnt <= iscu_pkg::CNT_HALFHR_MAX) begin
      r = 16'(cnt - iscu_pkg::CNT_HALFHR_BASE) * 16'(iscu_pkg::SEC_PER_HALFHR);
    end else if (cnt == iscu_pkg::CNT_21MIN) begin
      r = 16'(iscu_pkg::SEC_21MIN);
    end else if (cnt == iscu_pkg::CNT_8HR) begin
      r = 16'(iscu_pkg::SEC_8HR);
    end else if (cnt == iscu_pkg::CNT_21M15S) begin
      r = 16'(iscu_pkg::SEC_21M15S);
    end else begin
      // reserved code: behave as disabled rather than guess a period
      r = 16'h0000;
    end
    return r;
  endfunction : timeout_sec

  // ***********************
  // registers
  // ***********************
  iscu_mode_type mode_reg, mode_next;
  logic busy_reg, busy_next;
  logic irq_reg, irq_next;
  logic spinup_reg, spinup_next;
  logic geom_pend_reg, geom_pend_next;
  logic [7:0] geom_sec_reg, geom_sec_next;
  logic [3:0] geom_head_reg, geom_head_next;
  logic sb_en_reg, sb_en_next;
  logic [15:0] sb_cnt_reg, sb_cnt_next;
  logic [5:0] spd_cnt_reg, spd_cnt_next;
  logic [23:0] tick_cnt_reg;
  logic tick_reg;

  // ***********************
  // decode
  // ***********************
  // strobes while busy are dropped with no sign; the host waits for busy to clear
  wire logic take_cmd = cmd_wr_in && !busy_reg;
  wire logic is_idle = take_cmd && cmd_code_in == iscu_pkg::CMD_IDLE;
  wire logic is_idle_imm = take_cmd && cmd_code_in == iscu_pkg::CMD_IDLE_IMM;
  wire logic is_geom = take_cmd && cmd_code_in == iscu_pkg::CMD_INIT_GEOM;
  wire logic [15:0] new_timeout = timeout_sec(sector_count_in);
  wire logic enter_idle = is_idle || is_idle_imm;
  wire logic sb_expire = sb_en_reg && tick_reg && sb_cnt_reg == 16'h0001;
  wire logic spd_expire = mode_reg == PM_IDLE && tick_reg && spd_cnt_reg == 6'h01;
  // tick phase is not realigned on a command, so the first second may be short
  wire logic sb_dec = sb_en_reg && tick_reg && sb_cnt_reg != 16'h0000;
  wire logic spd_dec = mode_reg == PM_IDLE && tick_reg && spd_cnt_reg != 6'h00;

  // ***********************
  // one-second tick
  // ***********************
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_cnt_reg <= 24'h000000;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == 24'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 24'h000000;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 24'h000001;
      tick_reg <= 1'b0;
    end
  end

  // ***********************
  // command and power logic
  // ***********************
  always_comb begin
    mode_next = mode_reg;
    busy_next = busy_reg;
    irq_next = 1'b0;
    spinup_next = 1'b0;
    geom_pend_next = 1'b0;
    geom_sec_next = geom_sec_reg;
    geom_head_next = geom_head_reg;
    sb_en_next = sb_en_reg;
    sb_cnt_next = sb_cnt_reg;
    spd_cnt_next = spd_cnt_reg;
    if (sb_dec) begin
      sb_cnt_next = sb_cnt_reg - 16'h0001;
    end
    if (spd_dec) begin
      spd_cnt_next = spd_cnt_reg - 6'h01;
    end
    // whichever timer runs out first wins; both lead only to standby
    if (spd_expire || sb_expire) begin
      mode_next = PM_STANDBY;
    end
    if (geom_pend_reg) begin
      busy_next = 1'b0;
      irq_next = 1'b1;
    end
    if (enter_idle) begin
      mode_next = PM_IDLE;
      busy_next = 1'b0;
      irq_next = 1'b1;
      spinup_next = !spindle_turning_in;
      spd_cnt_next = 6'(iscu_pkg::SPINDOWN_SEC);
    end
    if (is_idle) begin
      sb_en_next = new_timeout != 16'h0000;
      sb_cnt_next = new_timeout;
    end
    if (is_geom) begin
      busy_next = 1'b1;
      geom_pend_next = 1'b1;
      geom_sec_next = sector_count_in;
      geom_head_next = drive_head_in;
    end
  end

  // ***********************
  // state registers
  // ***********************
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_reg <= PM_ACTIVE;
      busy_reg <= 1'b0;
      irq_reg <= 1'b0;
      spinup_reg <= 1'b0;
      geom_pend_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      busy_reg <= busy_next;
      irq_reg <= irq_next;
      spinup_reg <= spinup_next;
      geom_pend_reg <= geom_pend_next;
    end
  end

  // ***********************
  // geometry store
  // ***********************
  // no range check here: a bad geometry only matters to later media commands
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      geom_sec_reg <= 8'h00;
      geom_head_reg <= 4'h0;
    end else begin
      geom_sec_reg <= geom_sec_next;
      geom_head_reg <= geom_head_next;
    end
  end

  // ***********************
  // timer registers
  // ***********************
  // enable survives reaching standby; the count halts at zero
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sb_en_reg <= 1'b0;
      sb_cnt_reg <= 16'h0000;
      spd_cnt_reg <= 6'h00;
    end else begin
      sb_en_reg <= sb_en_next;
      sb_cnt_reg <= sb_cnt_next;
      spd_cnt_reg <= spd_cnt_next;
    end
  end

  // ***********************
  // outputs
  // ***********************
  assign busy_out = busy_reg;
  assign irq_out = irq_reg;
  assign spinup_req_out = spinup_reg;
  assign power_mode_out = mode_reg;
  assign standby_enabled_out = sb_en_reg;
  assign geom_sectors_out = geom_sec_reg;
  assign geom_heads_m1_out = geom_head_reg;
endmodule : iscu_unit

/* iscu_checker.sv */
module iscu_checker #(
  parameter int TICK_CYCLES = iscu_pkg::TICK_CYCLES
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic cmd_wr_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [7:0] sector_count_in,
  input wire logic spindle_turning_in,
  input wire logic busy_out,
  input wire logic irq_out,
  input wire logic spinup_req_out,
  input wire logic [1:0] power_mode_out,
  input wire logic standby_enabled_out,
  input wire logic [7:0] geom_sectors_out
);
  // ****
  // props
  // ****
  localparam int STBY_MAX = 6 * TICK_CYCLES;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  wire logic tk = cmd_wr_in && !busy_out;
  wire logic idl = tk && cmd_code_in == iscu_pkg::CMD_IDLE;
  wire logic imm = tk && cmd_code_in == iscu_pkg::CMD_IDLE_IMM;
  wire logic geo = tk && cmd_code_in == iscu_pkg::CMD_INIT_GEOM;
  wire logic [7:0] sc = sector_count_in;
  // cycles since an idle with count 01h; cleared once standby shows
  int five_cnt;
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      five_cnt <= 0;
    end else if (idl) begin
      five_cnt <= (sc == 8'h01) ? 1 : 0;
    end else if (power_mode_out == 2'h2) begin
      five_cnt <= 0;
    end else if (five_cnt != 0) begin
      five_cnt <= five_cnt + 1;
    end
  end
  AST_IDLE: assert property (idl |=> irq_out && power_mode_out == 2'h1) else $error("idle");
  AST_SPIN: assert property (idl |=> spinup_req_out == !$past(spindle_turning_in)) else $error("spin");
  AST_ARM: assert property (idl && sc != 8'h0 && sc != 8'hfe |=> standby_enabled_out) else $error("arm");
  AST_OFF: assert property (idl && sc == 8'h0 |=> !standby_enabled_out) else $error("off");
  AST_FIVE: assert property (five_cnt <= STBY_MAX) else $error("tmo");
  AST_IMM: assert property (imm |=> irq_out && $stable(standby_enabled_out)) else $error("imm");
  AST_GEOM: assert property (geo |=> busy_out && geom_sectors_out == $past(sc) ##1 !busy_out && irq_out) else $error("geo");
  AST_PULSE: assert property (irq_out && !tk |=> !irq_out) else $error("irq");
  cover property (idl);
  cover property (imm);
  cover property (geo);
  cover property (power_mode_out == 2'h2);
endmodule : iscu_checker
bind iscu_unit iscu_checker #(.TICK_CYCLES(TICK_CYCLES)) iscu_checker_i (.*);

/* iscu_host.sv */
module iscu_host (
  input wire logic mclk_in,
  input wire logic busy_in,
  input wire logic irq_in,
  output logic cmd_wr_out,
  output logic [7:0] cmd_code_out,
  output logic [7:0] sector_count_out,
  output logic [3:0] drive_head_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic done = 1'b0;
  initial cmd_wr_out = 1'b0;
  // ****
  // write
  // ****
  task send(input logic [7:0] c, input logic [7:0] s, input logic [3:0] h);
    @(negedge mclk_in);
    while (busy_in !== 1'b0) @(negedge mclk_in);
    cmd_wr_out = 1'b1;
    cmd_code_out = c;
    sector_count_out = s;
    drive_head_out = h;
    done = 1'b0;
    repeat (4) begin
      @(negedge mclk_in);
      // released lines must not keep the old command
      cmd_wr_out = 1'b0;
      cmd_code_out = ~c;
      sector_count_out = ~s;
      drive_head_out = ~h;
      if (irq_in === 1'b1) done = 1'b1;
    end
  endtask : send
endmodule : iscu_host

/* tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic spin = 1'b0;
  logic cmd_wr, busy, irq, spinup, armed;
  logic [7:0] code, sc, g_sec, r;
  logic [3:0] dh, g_hd;
  logic [1:0] mode;
  logic [7:0] cnt [9] = '{8'h00, 8'h01, 8'hf0, 8'hf1, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hff};
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  int spins = 0;
  int seed = 50;
  always #50 mclk_in = ~mclk_in;
  iscu_unit #(.TICK_CYCLES(10)) iscu_unit_i (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .cmd_wr_in(cmd_wr), .cmd_code_in(code), .sector_count_in(sc), .drive_head_in(dh),
    .spindle_turning_in(spin), .busy_out(busy), .irq_out(irq), .spinup_req_out(spinup),
    .power_mode_out(mode), .standby_enabled_out(armed), .geom_sectors_out(g_sec),
    .geom_heads_m1_out(g_hd));
  iscu_host iscu_host_i (.mclk_in(mclk_in), .busy_in(busy), .irq_in(irq),
    .cmd_wr_out(cmd_wr), .cmd_code_out(code), .sector_count_out(sc), .drive_head_out(dh));
  // ****
  // checks
  // ****
  function logic exp_armed(input logic [7:0] s);
    return s != 8'h00 && s != 8'hfe;
  endfunction : exp_armed
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task close_out;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // falling edge: outputs launched on the rising edge have settled
  always @(negedge mclk_in) begin
    cycles++;
    if (spinup === 1'b1) spins++;
    if (cycles == 30000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(negedge mclk_in);
    resetn_in = 1'b1;
    chk("mode", 8'h0, {6'h0, mode});
    for (int i = 0; i < 9; i++) begin
      spin = i[0];
      iscu_host_i.send(iscu_pkg::CMD_IDLE, cnt[i], 4'h0);
      chk("irq", 8'h1, {7'h0, iscu_host_i.done});
      chk("mode", 8'h1, {6'h0, mode});
      chk("armed", {7'h0, exp_armed(cnt[i])}, {7'h0, armed});
    end
    chk("spinups", 8'h5, 8'(spins));
    iscu_host_i.send(iscu_pkg::CMD_IDLE, 8'h01, 4'h0);
    iscu_host_i.send(iscu_pkg::CMD_IDLE_IMM, 8'h00, 4'h0);
    chk("armed", 8'h1, {7'h0, armed});
    repeat (60) @(negedge mclk_in);
    chk("mode", 8'h2, {6'h0, mode});
    iscu_host_i.send(iscu_pkg::CMD_IDLE, 8'h00, 4'h0);
    repeat (500) @(negedge mclk_in);
    chk("mode", 8'h1, {6'h0, mode});
    chk("armed", 8'h0, {7'h0, armed});
    repeat (150) @(negedge mclk_in);
    chk("mode", 8'h2, {6'h0, mode});
    for (int i = 0; i < 10; i++) begin
      r = (i < 2) ? {8{i[0]}} : 8'($random(seed));
      iscu_host_i.send(iscu_pkg::CMD_INIT_GEOM, r, r[7:4]);
      chk("sectors", r, g_sec);
      chk("heads", {4'h0, r[7:4]}, {4'h0, g_hd});
      chk("irq", 8'h1, {7'h0, iscu_host_i.done});
      chk("busy", 8'h0, {7'h0, busy});
    end
    close_out();
  end
endmodule : tb
